// >>> hw/acs_pkg.sv
// Package for the ADC conversion sequencer: register map, field layout,
// reset values, state encoding and timing constants.
// Assumes a 32-bit APB slave with byte addresses and word-aligned registers.
package acs_pkg;

    // =====================================================================
    // Register byte offsets.
    localparam logic [7:0] OFF_CTRL        = 8'h00;
    localparam logic [7:0] OFF_CFG_TWO     = 8'h04;
    localparam logic [7:0] OFF_CFG_ONE     = 8'h08;
    localparam logic [7:0] OFF_CFG_THREE   = 8'h0C;
    localparam logic [7:0] OFF_CFG_FOUR    = 8'h10;
    localparam logic [7:0] OFF_STATUS      = 8'h14;
    localparam logic [7:0] OFF_RESULT      = 8'h18;

    // =====================================================================
    // Field positions and widths.
    localparam int CTRL_START_BIT  = 0;
    localparam int CTRL_SEC_BIT    = 1;
    localparam int CTRL_CONT_BIT   = 2;
    localparam int FS_LSB          = 6;
    localparam int BG_LSB          = 0;
    localparam int OSR_LSB         = 2;
    localparam int NEL_LSB         = 5;
    localparam int ST_BUSY_BIT     = 0;
    localparam int ST_DONE_BIT     = 1;
    localparam int CODE_W          = 7;
    localparam int RESULT_W        = 16;

    // =====================================================================
    // Reset values.
    localparam logic [1:0] FS_RST      = 2'h0;
    localparam logic [2:0] OSR_RST     = 3'h0;
    localparam logic [1:0] NEL_RST     = 2'h1;
    localparam logic [1:0] BG_RST      = 2'h0;
    localparam logic [6:0] GAIN_RST    = 7'h0C;
    localparam logic [6:0] OFFSET_RST  = 7'h00;

    // =====================================================================
    // Bandgap modes.
    localparam logic [1:0] BG_HIGH     = 2'h0;
    localparam logic [1:0] BG_LOW      = 2'h1;
    localparam logic [1:0] BG_TOG_FULL = 2'h2;
    localparam logic [1:0] BG_TOG_HALF = 2'h3;

    // =====================================================================
    // Conversion arithmetic: OSR = 2^(3+sel), result scaled to 2^15 full scale.
    localparam int OSR_EXP_BASE    = 3;
    localparam int SCALE_EXP_BASE  = 12;
    localparam logic [15:0] SAT_POS = 16'h7FFF;
    localparam logic [15:0] SAT_NEG = 16'h8000;

    // =====================================================================
    // Oversampling clock: 4 MHz oscillator divided by 64 >> sample rate code.
    localparam int OSC_HZ_DEFAULT  = 4_000_000;
    localparam int CLK_HZ_DEFAULT  = 250_000_000;
    localparam int FS_DIV_SLOWEST  = 64;

    // Sequencer states, one-hot.
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ELEM  = 3'b010,
        ST_QUANT = 3'b100
    } acs_state_t;

endpackage

// >>> hw/acs_fs_div.sv
// Oversampling-rate divider: one-cycle enable at the selected fs.
// Assumes the system clock is an integer multiple of the 4 MHz base / 8.
`timescale 1ns/1ps

module acs_fs_div #(
    parameter int CLK_HZ = acs_pkg::CLK_HZ_DEFAULT,
    parameter int OSC_HZ = acs_pkg::OSC_HZ_DEFAULT
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [1:0] rate_sel,
    output logic            fs_tick
);

    // System cycles per fs period for the slowest code (divide by 64).
    localparam int SLOW_CYC = (CLK_HZ / 1000) * acs_pkg::FS_DIV_SLOWEST / (OSC_HZ / 1000);

    // Refuse clock ratios that cannot give every fs rate as a whole cycle count.
    if (((CLK_HZ / 1000) * 8) % (OSC_HZ / 1000) != 0 || SLOW_CYC > 65535) begin : g_bad_ratio
        $error("acs_fs_div: clock cannot be divided down to the fs rates");
    end

    logic [15:0] cnt_r;
    logic [15:0] period_m1;

    // Each faster code halves the period of the code below it.
    assign period_m1 = 16'(SLOW_CYC >> rate_sel) - 16'h0001;

    // Divider counter; >= guards a switch to a shorter period mid-count.
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r   <= 16'h0000;
            fs_tick <= 1'b0;
        end else if (cnt_r >= period_m1) begin
            cnt_r   <= 16'h0000;
            fs_tick <= 1'b1;
        end else begin
            cnt_r   <= cnt_r + 16'h0001;
            fs_tick <= 1'b0;
        end
    end

endmodule

// >>> hw/acs_top.sv
// Conversion sequencer for an incremental oversampling ADC, with APB
// register access. Assumes the analog modulator delivers one decision bit
// per oversampling period on MOD_BIT, asynchronous to CLK_SYS.
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps

module acs_top #(
    parameter int CLK_HZ = acs_pkg::CLK_HZ_DEFAULT,
    parameter int OSC_HZ = acs_pkg::OSC_HZ_DEFAULT
) (
    input  wire logic        CLK_SYS,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        MOD_BIT,
    output logic             INTEG_RESET,
    output logic             CHOP_POL,
    output logic             BANDGAP_STATE,
    output logic      [6:0]  STAGE3_GAIN_CODE,
    output logic      [7:0]  STAGE3_OFFSET_TWOS,
    output logic             CONV_BUSY
);

    // =====================================================================
    // Configuration and status registers.
    logic [1:0]  sample_rate_select_r;
    logic [2:0]  oversample_ratio_select_r;
    logic [1:0]  elem_conv_count_select_r;
    logic [1:0]  bandgap_mode_r;
    logic        continuous_r;
    logic [6:0]  stage3_gain_code_r;
    logic [6:0]  stage3_offset_code_r;
    logic        done_r;
    logic [15:0] result_r;

    // Sequencer state. Local copies of the state codes keep the case arms short,
    // since nothing is imported from the package.
    localparam acs_pkg::acs_state_t ST_IDLE  = acs_pkg::ST_IDLE;
    localparam acs_pkg::acs_state_t ST_ELEM  = acs_pkg::ST_ELEM;
    localparam acs_pkg::acs_state_t ST_QUANT = acs_pkg::ST_QUANT;

    acs_pkg::acs_state_t state_r;
    logic [10:0] per_cnt_r;
    logic [3:0]  elem_idx_r;
    logic        pol_r;
    logic        bg_tog_r;
    logic signed [15:0] acc_r;
    logic        mod_s1_r;
    logic        mod_s2_r;
    logic        fs_tick;

    // =====================================================================
    // APB decode. One wait state: PREADY rises in the second access cycle.
    wire apb_access = PSEL & PENABLE;
    wire apb_done   = apb_access & PREADY;
    wire apb_wr     = apb_done & PWRITE;
    wire apb_rd_cap = apb_access & ~PREADY & ~PWRITE;
    wire sel_ctrl   = (PADDR == acs_pkg::OFF_CTRL);
    wire sel_two    = (PADDR == acs_pkg::OFF_CFG_TWO);
    wire sel_one    = (PADDR == acs_pkg::OFF_CFG_ONE);
    wire sel_three  = (PADDR == acs_pkg::OFF_CFG_THREE);
    wire sel_four   = (PADDR == acs_pkg::OFF_CFG_FOUR);
    wire sel_status = (PADDR == acs_pkg::OFF_STATUS);
    wire sel_result = (PADDR == acs_pkg::OFF_RESULT);
    wire mapped     = sel_ctrl | sel_two | sel_one | sel_three | sel_four |
                      sel_status | sel_result;

    // Either trigger bit written as one starts a conversion.
    wire trigger = apb_wr & sel_ctrl & (PWDATA[acs_pkg::CTRL_START_BIT] |
                                        PWDATA[acs_pkg::CTRL_SEC_BIT]);

    // Read mux; trigger bits always read zero since they act on write only.
    wire [31:0] rd_mux =
        sel_ctrl   ? {29'h0000_0000, continuous_r, 2'h0} :
        sel_two    ? {24'h00_0000, sample_rate_select_r, 6'h00} :
        sel_one    ? {25'h000_0000, elem_conv_count_select_r,
                      oversample_ratio_select_r, bandgap_mode_r} :
        sel_three  ? {25'h000_0000, stage3_gain_code_r} :
        sel_four   ? {25'h000_0000, stage3_offset_code_r} :
        sel_status ? {30'h0000_0000, done_r, CONV_BUSY} :
        sel_result ? {16'h0000, result_r} : 32'h0000_0000;

    // Bus handshake and read data capture.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end else begin
            PREADY  <= apb_access & ~PREADY;
            PSLVERR <= apb_access & ~PREADY & ~mapped;
            if (apb_rd_cap) begin
                PRDATA <= rd_mux;
            end
        end
    end

    // Configuration writes. A count code below one leaves offset uncancelled;
    // the hardware accepts it, it is software's job to avoid it.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            continuous_r              <= 1'b0;
            sample_rate_select_r      <= acs_pkg::FS_RST;
            oversample_ratio_select_r <= acs_pkg::OSR_RST;
            elem_conv_count_select_r  <= acs_pkg::NEL_RST;
            bandgap_mode_r            <= acs_pkg::BG_RST;
            stage3_gain_code_r        <= acs_pkg::GAIN_RST;
            stage3_offset_code_r      <= acs_pkg::OFFSET_RST;
        end else if (apb_wr) begin
            if (sel_ctrl) begin
                continuous_r <= PWDATA[acs_pkg::CTRL_CONT_BIT];
            end
            if (sel_two) begin
                sample_rate_select_r <= PWDATA[acs_pkg::FS_LSB +: 2];
            end
            if (sel_one) begin
                bandgap_mode_r            <= PWDATA[acs_pkg::BG_LSB +: 2];
                oversample_ratio_select_r <= PWDATA[acs_pkg::OSR_LSB +: 3];
                elem_conv_count_select_r  <= PWDATA[acs_pkg::NEL_LSB +: 2];
            end
            if (sel_three) begin
                stage3_gain_code_r <= PWDATA[acs_pkg::CODE_W-1:0];
            end
            if (sel_four) begin
                stage3_offset_code_r <= PWDATA[acs_pkg::CODE_W-1:0];
            end
        end
    end

    // =====================================================================
    // Oversampling enable from the divided oscillator rate.
    // The divider free-runs, so a conversion's first tick has arbitrary phase.
    acs_fs_div #(
        .CLK_HZ (CLK_HZ),
        .OSC_HZ (OSC_HZ)
    ) u_fs_div (
        .clk      (CLK_SYS),
        .rst      (RST),
        .rate_sel (sample_rate_select_r),
        .fs_tick  (fs_tick)
    );

    // The modulator bit is asynchronous: two flops before any use.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            mod_s1_r <= 1'b0;
            mod_s2_r <= 1'b0;
        end else begin
            mod_s1_r <= MOD_BIT;
            mod_s2_r <= mod_s1_r;
        end
    end

    // =====================================================================
    // Derived conversion settings.
    // OSR = 2^(3+code) periods of integration after the reset period.
    wire [10:0] osr_val  = 11'(1) << (acs_pkg::OSR_EXP_BASE + oversample_ratio_select_r);
    // Elementary count = 2^code.
    wire [3:0]  nel_val  = 4'(1) << elem_conv_count_select_r;
    wire        elem_end = (per_cnt_r == osr_val);
    wire        last_el  = (elem_idx_r == nel_val - 4'h1);
    // Mean over the elementary conversions scaled to 2^15 full scale; the
    // shift is 12 - osr - nel, which is always between 2 and 12, so the
    // 16-bit word keeps every accumulator bit except at positive full scale, 2^15, which saturates to 7FFF.
    wire [3:0]  scale_sh = 4'(acs_pkg::SCALE_EXP_BASE) - {1'b0, oversample_ratio_select_r}
                           - {2'b00, elem_conv_count_select_r};
    wire signed [31:0] scaled = 32'(acc_r) <<< scale_sh;
    // Saturate to the closest full-scale code.
    wire [15:0] sat_res  = (scaled > 32'sh0000_7FFF) ? acs_pkg::SAT_POS :
                           (scaled < -32'sh0000_8000) ? acs_pkg::SAT_NEG :
                           scaled[15:0];
    // Decision mapped to +-1, with sign inverted during the negative chop
    // phase so the amplifier offset cancels between pairs.
    wire signed [15:0] step = (mod_s2_r ^ pol_r) ? 16'sh0001 : -16'sh0001;
    wire start_new = trigger & (state_r == ST_IDLE);

    // =====================================================================
    // Sequencer: N elementary conversions of OSR+1 periods each, then one
    // quantization period, N*(OSR+1)+1 fs periods in total.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state_r    <= ST_IDLE;
            per_cnt_r  <= 11'h000;
            elem_idx_r <= 4'h0;
            pol_r      <= 1'b0;
            bg_tog_r   <= 1'b0;
            acc_r      <= 16'sh0000;
            result_r   <= 16'h0000;
            done_r     <= 1'b0;
        end else begin
            // Done is sticky, cleared by writing one; a finishing conversion wins.
            if (apb_wr & sel_status & PWDATA[acs_pkg::ST_DONE_BIT]) begin
                done_r <= 1'b0;
            end
            case (state_r)
                ST_IDLE: begin
                    if (start_new) begin
                        state_r    <= ST_ELEM;
                        per_cnt_r  <= 11'h000;
                        elem_idx_r <= 4'h0;
                        pol_r      <= 1'b0;
                        acc_r      <= 16'sh0000;
                    end
                end
                ST_ELEM: begin
                    if (fs_tick) begin
                        // Period zero resets the integrator; no decision taken.
                        if (per_cnt_r != 11'h000) begin
                            acc_r <= acc_r + step;
                        end
                        if (elem_end) begin
                            per_cnt_r  <= 11'h000;
                            elem_idx_r <= elem_idx_r + 4'h1;
                            pol_r      <= ~pol_r;
                            // Bandgap toggle at full or half the elementary rate.
                            if (bandgap_mode_r == acs_pkg::BG_TOG_FULL ||
                                (bandgap_mode_r == acs_pkg::BG_TOG_HALF && elem_idx_r[0])) begin
                                bg_tog_r <= ~bg_tog_r;
                            end
                            if (last_el) begin
                                state_r <= ST_QUANT;
                            end
                        end else begin
                            per_cnt_r <= per_cnt_r + 11'h001;
                        end
                    end
                end
                ST_QUANT: begin
                    if (fs_tick) begin
                        result_r <= sat_res;
                        done_r   <= 1'b1;
                        // Free-running restarts at once with fresh counters.
                        if (continuous_r) begin
                            state_r    <= ST_ELEM;
                            per_cnt_r  <= 11'h000;
                            elem_idx_r <= 4'h0;
                            pol_r      <= 1'b0;
                            acc_r      <= 16'sh0000;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // =====================================================================
    // Analog-facing outputs, all registered.
    // Offset code: top bit is the sign, low six bits the magnitude.
    wire [7:0] offset_twos = stage3_offset_code_r[6]
                             ? (8'h00 - {2'b00, stage3_offset_code_r[5:0]})
                             : {2'b00, stage3_offset_code_r[5:0]};
    wire       bg_level    = (bandgap_mode_r == acs_pkg::BG_HIGH) ? 1'b1 :
                             (bandgap_mode_r == acs_pkg::BG_LOW)  ? 1'b0 : bg_tog_r;

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            INTEG_RESET        <= 1'b0;
            CHOP_POL           <= 1'b0;
            BANDGAP_STATE      <= 1'b1;
            STAGE3_GAIN_CODE   <= acs_pkg::GAIN_RST;
            STAGE3_OFFSET_TWOS <= 8'h00;
            CONV_BUSY          <= 1'b0;
        end else begin
            INTEG_RESET        <= (state_r == ST_ELEM) && (per_cnt_r == 11'h000);
            CHOP_POL           <= pol_r;
            BANDGAP_STATE      <= bg_level;
            STAGE3_GAIN_CODE   <= stage3_gain_code_r;
            STAGE3_OFFSET_TWOS <= offset_twos;
            CONV_BUSY          <= (state_r != ST_IDLE);
        end
    end

endmodule

// >>> verif/acs_top_monitor.sv
// Port checker for the conversion sequencer: APB timing and decode, trigger
// start, integrator reset placement and the stage three code outputs.
// Assumes it is bound to acs_top and sees nothing but that module's ports.
`timescale 1ns/1ps

module acs_top_monitor #(
    parameter int CLK_HZ = acs_pkg::CLK_HZ_DEFAULT,
    parameter int OSC_HZ = acs_pkg::OSC_HZ_DEFAULT
) (
    input wire logic        CLK_SYS,
    input wire logic        RST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        MOD_BIT,
    input wire logic        INTEG_RESET,
    input wire logic        CHOP_POL,
    input wire logic        BANDGAP_STATE,
    input wire logic [6:0]  STAGE3_GAIN_CODE,
    input wire logic [7:0]  STAGE3_OFFSET_TWOS,
    input wire logic        CONV_BUSY
);
    // =====================================================================
    // One clock domain, so one default clock and one disable condition.
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    // A completed write; code outputs may only move in the two cycles after one.
    wire wr_ok    = PSEL && PENABLE && PREADY && PWRITE;
    wire unmapped = (PADDR > acs_pkg::OFF_RESULT) || (PADDR[1:0] != 2'b00);

    sequence setup_s;
        PSEL && !PENABLE ##1 PSEL && PENABLE;
    endsequence
    sequence trig_s;
        wr_ok && PADDR == acs_pkg::OFF_CTRL && (|PWDATA[1:0]) && !CONV_BUSY;
    endsequence

    // =====================================================================
    ready_wait_a: assert property (setup_s |-> !PREADY ##1 PREADY)
        else $error("pready not in second access cycle");
    ready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("pready longer than one cycle");
    err_decode_a: assert property (PREADY |-> PSLVERR == unmapped)
        else $error("pslverr does not match address decode");
    err_data_a: assert property (PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h0000_0000)
        else $error("unmapped read data not zero");
    result_width_a: assert property (PREADY && !PWRITE && PADDR == acs_pkg::OFF_RESULT
        |-> PRDATA[31:16] == 16'h0000)
        else $error("result upper half not zero");
    trig_start_a: assert property (trig_s |-> ##[1:2] CONV_BUSY)
        else $error("trigger did not start a conversion");
    integ_busy_a: assert property (INTEG_RESET |-> CONV_BUSY)
        else $error("integrator reset outside a conversion");
    chop_first_a: assert property ($rose(CONV_BUSY) |-> !CHOP_POL)
        else $error("first elementary conversion not in positive phase");
    gain_hold_a: assert property (!$past(wr_ok) && !$past(wr_ok, 2)
        |-> $stable(STAGE3_GAIN_CODE))
        else $error("gain code moved without a write");
    offset_hold_a: assert property (!$past(wr_ok) && !$past(wr_ok, 2)
        |-> $stable(STAGE3_OFFSET_TWOS))
        else $error("offset code moved without a write");
endmodule

bind acs_top acs_top_monitor #(.CLK_HZ(CLK_HZ), .OSC_HZ(OSC_HZ)) u_mon (
    .CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .MOD_BIT(MOD_BIT), .INTEG_RESET(INTEG_RESET),
    .CHOP_POL(CHOP_POL), .BANDGAP_STATE(BANDGAP_STATE),
    .STAGE3_GAIN_CODE(STAGE3_GAIN_CODE), .STAGE3_OFFSET_TWOS(STAGE3_OFFSET_TWOS),
    .CONV_BUSY(CONV_BUSY));

// >>> verif/acs_top_tb.sv
// Self-checking bench for the conversion sequencer, driven over APB.
// Assumes a 125 MHz oscillator figure so the fs tick comes every 16 to 128 clocks.
`timescale 1ns/1ps

module acs_top_tb;
    localparam int OSC = 125_000_000;
    logic        CLK_SYS = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, MOD_BIT = 0;
    logic [7:0]  PADDR = '0;
    logic [31:0] PWDATA = '0, PRDATA, rd;
    logic        PREADY, PSLVERR, INTEG_RESET, CHOP_POL, BANDGAP_STATE, CONV_BUSY, er;
    logic [6:0]  STAGE3_GAIN_CODE;
    logic [7:0]  STAGE3_OFFSET_TWOS;
    logic        integ_q = 0, mod_lvl = 0, mod_chop = 0, bgs;
    int          n_fail = 0, check_count = 0, cyc = 0, busy_cyc = 0, n_integ = 0;

    acs_top #(.OSC_HZ(OSC)) u_dut (
        .CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .MOD_BIT(MOD_BIT), .INTEG_RESET(INTEG_RESET),
        .CHOP_POL(CHOP_POL), .BANDGAP_STATE(BANDGAP_STATE),
        .STAGE3_GAIN_CODE(STAGE3_GAIN_CODE), .STAGE3_OFFSET_TWOS(STAGE3_OFFSET_TWOS),
        .CONV_BUSY(CONV_BUSY));

    // =====================================================================
    // Clock of 4 ns period.
    always #2 CLK_SYS = ~CLK_SYS;

    // Modulator stand-in: a fixed decision, or one that follows the chop phase
    // so that a steady input survives the offset cancellation.
    always @(posedge CLK_SYS) MOD_BIT <= mod_lvl ^ (mod_chop & CHOP_POL);

    // Timeout, busy length and integrator reset count; long runs end here.
    always @(posedge CLK_SYS) begin
        cyc <= cyc + 1;
        integ_q <= INTEG_RESET;
        if (CONV_BUSY === 1'b1) busy_cyc <= busy_cyc + 1;
        if (INTEG_RESET === 1'b1 && integ_q === 1'b0) n_integ <= n_integ + 1;
        if (cyc == 40000) begin
            n_fail++;
            test_done();
        end
    end

    // =====================================================================
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer; an idle cycle follows so drivers never double-assign.
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        PSEL <= 1;
        PENABLE <= 0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS) PENABLE <= 1;
        do @(posedge CLK_SYS); while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 0;
        PENABLE <= 0;
        @(posedge CLK_SYS);
    endtask

    // One on-request conversion with its time, reset count, result and status.
    task conv(input logic [1:0] fs, input logic [2:0] osr, input logic [1:0] nel,
              input logic [1:0] bg, input logic [1:0] m, input int trg, input logic [15:0] ex);
        int t, p, b0, i0;
        t = (1 << nel) * ((8 << osr) + 1) + 1;
        p = 16 << (3 - fs);
        mod_lvl <= m[0];
        mod_chop <= m[1];
        xfer(1, acs_pkg::OFF_CFG_TWO, 32'(fs) << acs_pkg::FS_LSB);
        xfer(1, acs_pkg::OFF_CFG_ONE, (32'(nel) << acs_pkg::NEL_LSB)
             | (32'(osr) << acs_pkg::OSR_LSB) | 32'(bg));
        b0 = busy_cyc;
        i0 = n_integ;
        xfer(1, acs_pkg::OFF_CTRL, 32'h0000_0001 << trg);
        xfer(1, acs_pkg::OFF_CTRL, 32'h0000_0001);
        check("busy", CONV_BUSY, 1);
        bgs = BANDGAP_STATE;
        while (CONV_BUSY === 1'b1) @(posedge CLK_SYS);
        check("time_min", (busy_cyc - b0) >= (t - 1) * p, 1);
        check("time_max", (busy_cyc - b0) <= t * p + 4, 1);
        check("elem_count", n_integ - i0, 1 << nel);
        if (bg < 2) check("bandgap", BANDGAP_STATE, bg != acs_pkg::BG_LOW);
        else check("bg_toggle", BANDGAP_STATE ^ bgs, bg[0] ? nel == 1 : nel == 0);
        xfer(0, acs_pkg::OFF_RESULT, 0);
        check("result", rd, {16'h0000, ex});
        xfer(0, acs_pkg::OFF_STATUS, 0);
        check("done", rd, 32'h0000_0002);
        xfer(1, acs_pkg::OFF_STATUS, 32'h0000_0002);
        xfer(0, acs_pkg::OFF_STATUS, 0);
        check("done_clr", rd, 32'h0000_0000);
    endtask

    task test_done();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // =====================================================================
    // Main sequence: reset values, decode, stage three codes, conversions.
    logic [7:0]  offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
    logic [31:0] rstv [7] = '{0, 0, 32'h0000_0020, 32'h0000_000C, 0, 0, 0};
    logic [6:0]  ocode [5] = '{7'h41, 7'h50, 7'h7F, 7'h40, 7'h01};
    logic [7:0]  otwos [5] = '{8'hFF, 8'hF0, 8'hC1, 8'h00, 8'h01};
    initial begin
        repeat (12) @(posedge CLK_SYS);
        RST <= 0;
        @(posedge CLK_SYS);
        check("bg_rst", BANDGAP_STATE, 1);
        check("gain_rst", STAGE3_GAIN_CODE, 7'h0C);
        for (int i = 0; i < 7; i++) begin
            xfer(0, offs[i], 0);
            check("reg_rst", rd, rstv[i]);
        end
        xfer(1, 8'h1C, 32'hFFFF_FFFF);
        xfer(0, 8'h1C, 0);
        check("unmapped_err", er, 1);
        check("unmapped_data", rd, 0);
        xfer(1, acs_pkg::OFF_CFG_THREE, 32'h0000_007F);
        repeat (2) @(posedge CLK_SYS);
        check("gain_max", STAGE3_GAIN_CODE, 7'h7F);
        for (int i = 0; i < 5; i++) begin
            xfer(1, acs_pkg::OFF_CFG_FOUR, 32'(ocode[i]));
            repeat (2) @(posedge CLK_SYS);
            check("offset", STAGE3_OFFSET_TWOS, otwos[i]);
        end
        conv(3, 0, 0, acs_pkg::BG_HIGH, 1, 0, 16'h7FFF);
        conv(3, 0, 1, acs_pkg::BG_LOW, 1, 1, 16'h0000);
        conv(2, 0, 0, acs_pkg::BG_TOG_FULL, 0, 0, 16'h8000);
        conv(0, 0, 0, acs_pkg::BG_TOG_HALF, 1, 1, 16'h7FFF);
        conv(1, 0, 2, acs_pkg::BG_LOW, 1, 0, 16'h0000);
        conv(3, 0, 3, acs_pkg::BG_HIGH, 0, 0, 16'h0000);
        conv(3, 1, 1, acs_pkg::BG_HIGH, 2, 1, 16'h8000);
        conv(3, 7, 0, acs_pkg::BG_HIGH, 1, 0, 16'h7FFF);
        // Free-running: done comes back after being cleared, busy never drops.
        xfer(1, acs_pkg::OFF_CFG_ONE, 0);
        xfer(1, acs_pkg::OFF_CTRL, 32'h0000_0005);
        repeat (200) @(posedge CLK_SYS);
        xfer(1, acs_pkg::OFF_STATUS, 32'h0000_0002);
        repeat (200) @(posedge CLK_SYS);
        xfer(0, acs_pkg::OFF_STATUS, 0);
        check("cont_status", rd, 32'h0000_0003);
        xfer(1, acs_pkg::OFF_CTRL, 0);
        while (CONV_BUSY === 1'b1) @(posedge CLK_SYS);
        xfer(0, acs_pkg::OFF_RESULT, 0);
        check("cont_result", rd, 32'h0000_7FFF);
        test_done();
    end
endmodule
